/* rtl/tpf_top.sv */
// Timer prescaler, external clock path and timer event flags
`timescale 1ns/1ps

// What this block does
// - Match flag sets two clocks after compare equal
// - Forced compare strobe never sets flag
// - Vector execution clears its flag
// - Write one clears flag, zero keeps
// - Overflow flag set on overflow tick in any waveform mode
// - Capture flag on pin event or TOP
// - Extended flags layout bits five to zero
// - Select one clocks timer each cycle
// - Taps divide by 8, 64, 256, 1024
// - Prescaler free running, shared by three
// - First divided tick within N+1 clocks
// - Prescaler reset restarts all timers' taps
// - Pin via high-transparent latch then register
// - Select seven rising, six falling edges
// - Pin edge to update 1.5-2.5 clocks
// - External clock bypasses prescaler entirely
// - Sync mode keeps prescaler reset bits
// - Clearing sync mode clears reset bits
// - Shared reset bit self-clears unless synced
// - Select zero gives no timer pulses
module tpf_top #(
    parameter int NUM_TIMERS = 3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [NUM_TIMERS*3-1:0] clock_select_field,
    input wire logic [NUM_TIMERS-1:0] ext_count_clock_pin,
    output logic [NUM_TIMERS-1:0] timer_tick,
    output logic async_prescaler_reset,
    input wire logic t1_tick_match_a,
    input wire logic t1_tick_match_b,
    input wire logic t1_tick_match_c,
    input wire logic t1_tick_overflow,
    input wire logic t1_force_compare_a,
    input wire logic t1_force_compare_b,
    input wire logic t1_force_compare_c,
    input wire logic t3_tick_match_a,
    input wire logic t3_tick_match_b,
    input wire logic t3_tick_match_c,
    input wire logic t3_tick_overflow,
    input wire logic t3_tick_top,
    input wire logic t3_capture_event,
    input wire logic t3_force_compare_a,
    input wire logic t3_force_compare_b,
    input wire logic t3_force_compare_c,
    input wire logic [3:0] t1_waveform_mode_field,
    input wire logic [3:0] t3_waveform_mode_field,
    input wire logic [3:0] t1_vector_ack,
    input wire logic [5:0] t3_vector_ack,
    output logic t1_match_a_flag,
    output logic t1_match_b_flag,
    output logic t1_match_c_flag,
    output logic t1_overflow_flag,
    output logic t3_capture_flag,
    output logic t3_match_a_flag,
    output logic t3_match_b_flag,
    output logic t3_match_c_flag,
    output logic t3_overflow_flag
);
    logic [9:0] presc_r;
    logic [9:0] presc_nxt;
    logic [7:0] sfc_r;
    logic [7:0] sfc_nxt;
    logic [3:0] t1_flags_r;
    logic [3:0] t1_flags_nxt;
    logic [5:0] ext_flags_r;
    logic [5:0] ext_flags_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [NUM_TIMERS-1:0] pin_latch;
    logic [NUM_TIMERS-1:0] pin_sync_r;
    logic [NUM_TIMERS-1:0] pin_prev_r;

    wire wr_flags = reg_wr && (reg_addr == tpf_pkg::TPF_ADDR_FLAGS);
    wire wr_sfc = reg_wr && (reg_addr == tpf_pkg::TPF_ADDR_SFC);
    wire wr_stat = reg_wr && (reg_addr == tpf_pkg::TPF_ADDR_STATUS);
    wire shared_reset = sfc_r[tpf_pkg::TPF_BIT_PSR_SHARED];
    wire sync_mode = sfc_r[tpf_pkg::TPF_BIT_SYNC];

    // Prescaler never looks at the selects, so taps keep phase across enables
    assign presc_nxt = shared_reset ? 10'h000 : presc_r + 10'h001;

    // Tap strobes: one cycle when the low bits are all ones, just before they wrap to zero
    wire tap8 = (presc_r[2:0] == 3'h7);
    wire tap64 = (presc_r[5:0] == 6'h3F);
    wire tap256 = (presc_r[7:0] == 8'hFF);
    wire tap1024 = (presc_r == 10'h3FF);

    // Control register: sync hold keeps the reset bits until sync clears
    always_comb begin
        sfc_nxt = sfc_r;
        if (wr_sfc) begin
            sfc_nxt = {reg_wdata[7], 3'h0, reg_wdata[3:0]};
        end
        if (!sfc_nxt[tpf_pkg::TPF_BIT_SYNC]) begin
            // Written bits act for one cycle then drop; a write that leaves sync mode drops them at once
            if (!wr_sfc || sync_mode) begin
                sfc_nxt[tpf_pkg::TPF_BIT_PSR_SHARED] = 1'b0;
                sfc_nxt[tpf_pkg::TPF_BIT_PSR_ASYNC] = 1'b0;
            end
        end
    end

    assign async_prescaler_reset = sfc_r[tpf_pkg::TPF_BIT_PSR_ASYNC];

    // Per-timer clock selection and external edge detection
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g = g + 1) begin : g_sel
            wire [2:0] cs = clock_select_field[g*3 +: 3];
            wire rise = pin_sync_r[g] && !pin_prev_r[g];
            wire fall = !pin_sync_r[g] && pin_prev_r[g];
            // Latch transparent while clock high, closes on falling edge
            always_latch begin
                if (clock) begin
                    pin_latch[g] = ext_count_clock_pin[g];
                end
            end
            always_comb begin
                case (cs)
                    tpf_pkg::TPF_CS_STOP: timer_tick[g] = 1'b0;
                    tpf_pkg::TPF_CS_DIRECT: timer_tick[g] = 1'b1;
                    tpf_pkg::TPF_CS_DIV8: timer_tick[g] = tap8;
                    tpf_pkg::TPF_CS_DIV64: timer_tick[g] = tap64;
                    tpf_pkg::TPF_CS_DIV256: timer_tick[g] = tap256;
                    tpf_pkg::TPF_CS_DIV1024: timer_tick[g] = tap1024;
                    tpf_pkg::TPF_CS_EXT_FALL: timer_tick[g] = fall;
                    tpf_pkg::TPF_CS_EXT_RISE: timer_tick[g] = rise;
                    default: timer_tick[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Overflow set on the timer's overflow tick in every mode; the waveform mode only picks the capture source
    wire t1_ctc = (t1_waveform_mode_field == tpf_pkg::TPF_WGM_CTC_OCR)
        || (t1_waveform_mode_field == tpf_pkg::TPF_WGM_CTC_ICR);
    wire t3_ctc = (t3_waveform_mode_field == tpf_pkg::TPF_WGM_CTC_OCR)
        || (t3_waveform_mode_field == tpf_pkg::TPF_WGM_CTC_ICR);
    wire t3_icr_top = (t3_waveform_mode_field == tpf_pkg::TPF_WGM_CTC_ICR)
        || (t3_waveform_mode_field[3:1] == 3'h7);
    wire t1_ovf_set = t1_tick_overflow && timer_tick[0];
    wire t3_ovf_set = t3_tick_overflow && timer_tick[NUM_TIMERS-1];
    wire t3_cap_set = t3_icr_top ? (t3_tick_top && timer_tick[NUM_TIMERS-1])
        : t3_capture_event;

    // Match inputs are the comparator equals; an equal with a timer tick is registered, then sets the flag one clock later
    logic [5:0] eq_r;
    wire [5:0] eq_now = {t1_tick_match_a, t1_tick_match_b, t1_tick_match_c,
        t3_tick_match_a, t3_tick_match_b, t3_tick_match_c};
    wire [5:0] force_now = {t1_force_compare_a, t1_force_compare_b, t1_force_compare_c,
        t3_force_compare_a, t3_force_compare_b, t3_force_compare_c};
    wire t1_adv = timer_tick[0];
    wire t3_adv = timer_tick[NUM_TIMERS-1];
    wire [5:0] eq_nxt = {{3{t1_adv}}, {3{t3_adv}}} & eq_now & ~force_now;
    wire [5:0] mset = eq_r;

    // Flag order t1: {A, B, overflow, C}
    wire [3:0] t1_set = {mset[5], mset[4], t1_ovf_set, mset[3]};
    wire [3:0] t1_wclr = wr_stat ? {reg_wdata[4], reg_wdata[3], reg_wdata[2],
        reg_wdata[0]} : 4'h0;
    assign t1_flags_nxt = (t1_flags_r & ~(t1_wclr | t1_vector_ack)) | t1_set;

    wire [5:0] ext_set = {t3_cap_set, mset[2], mset[1], t3_ovf_set, mset[0], mset[3]};
    wire [5:0] ext_wclr = wr_flags ? (reg_wdata[5:0] & tpf_pkg::TPF_FLAGS_MASK) : 6'h00;
    wire [5:0] ext_vclr = {t3_vector_ack[5:1], t1_vector_ack[0] | t3_vector_ack[0]};
    assign ext_flags_nxt = (ext_flags_r & ~(ext_wclr | ext_vclr)) | ext_set;

    // Read mux: status word mirrors timer one A, B and overflow flags at their own positions
    always_comb begin
        case (reg_addr)
            tpf_pkg::TPF_ADDR_FLAGS: rdata_nxt = {2'h0, ext_flags_r};
            tpf_pkg::TPF_ADDR_SFC: rdata_nxt = sfc_r;
            tpf_pkg::TPF_ADDR_STATUS: rdata_nxt = {3'h0, t1_flags_r[3], t1_flags_r[2],
                t1_flags_r[1], 2'h0};
            default: rdata_nxt = 8'h00;
        endcase
        if (!reg_rd) begin
            rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            presc_r <= 10'h000;
            sfc_r <= tpf_pkg::TPF_SFC_RST;
            t1_flags_r <= 4'h0;
            ext_flags_r <= 6'h00;
            eq_r <= 6'h00;
            rdata_r <= 8'h00;
            pin_sync_r <= '0;
            pin_prev_r <= '0;
        end else begin
            presc_r <= presc_nxt;
            sfc_r <= sfc_nxt;
            t1_flags_r <= t1_flags_nxt;
            ext_flags_r <= ext_flags_nxt;
            eq_r <= eq_nxt;
            rdata_r <= rdata_nxt;
            pin_sync_r <= pin_latch;
            pin_prev_r <= pin_sync_r;
        end
    end

    assign reg_rdata = rdata_r;
    assign t1_match_a_flag = t1_flags_r[3];
    assign t1_match_b_flag = t1_flags_r[2];
    assign t1_overflow_flag = t1_flags_r[1];
    assign t1_match_c_flag = ext_flags_r[0];
    assign t3_capture_flag = ext_flags_r[5];
    assign t3_match_a_flag = ext_flags_r[4];
    assign t3_match_b_flag = ext_flags_r[3];
    assign t3_overflow_flag = ext_flags_r[2];
    assign t3_match_c_flag = ext_flags_r[1];
endmodule // tpf_top

/* rtl/tpf_pkg.sv */
// Package: offsets, field positions and reset values of the timer support block
package tpf_pkg;
    localparam logic [1:0] TPF_ADDR_FLAGS = 2'h0;
    localparam logic [1:0] TPF_ADDR_SFC = 2'h1;
    localparam logic [1:0] TPF_ADDR_STATUS = 2'h2;
    localparam logic [7:0] TPF_FLAGS_RST = 8'h00;
    localparam logic [7:0] TPF_SFC_RST = 8'h00;
    localparam int TPF_BIT_T3_CAP = 5;
    localparam int TPF_BIT_T3_MA = 4;
    localparam int TPF_BIT_T3_MB = 3;
    localparam int TPF_BIT_T3_OVF = 2;
    localparam int TPF_BIT_T3_MC = 1;
    localparam int TPF_BIT_T1_MC = 0;
    localparam logic [5:0] TPF_FLAGS_MASK = 6'h3F;
    localparam int TPF_BIT_SYNC = 7;
    localparam int TPF_BIT_PSR_ASYNC = 1;
    localparam int TPF_BIT_PSR_SHARED = 0;
    localparam logic [3:0] TPF_SFC_RW_MASK = 4'hF;
    localparam int TPF_PRESC_W = 10;
    localparam logic [2:0] TPF_CS_STOP = 3'h0;
    localparam logic [2:0] TPF_CS_DIRECT = 3'h1;
    localparam logic [2:0] TPF_CS_DIV8 = 3'h2;
    localparam logic [2:0] TPF_CS_DIV64 = 3'h3;
    localparam logic [2:0] TPF_CS_DIV256 = 3'h4;
    localparam logic [2:0] TPF_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TPF_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TPF_CS_EXT_RISE = 3'h7;
    localparam logic [3:0] TPF_WGM_NORMAL = 4'h0;
    localparam logic [3:0] TPF_WGM_CTC_OCR = 4'h4;
    localparam logic [3:0] TPF_WGM_CTC_ICR = 4'hC;
endpackage

/* tb/tpf_ext_src.sv */
// External count clock source model
`timescale 1ns/1ps
module tpf_ext_src #(
    parameter int HALF = 3
) (
    input logic clock,
    input logic en,
    output logic pin
);
    int cnt_r = 0;
    initial pin = 1'b0;
    // Halves of several clocks; always stops low so enables see a steady pin
    always @(posedge clock) begin
        if (en || pin) begin
            cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
            if (cnt_r == HALF - 1) pin <= ~pin;
        end
    end
endmodule // tpf_ext_src

/* tb/tpf_top_props.sv */
// Checker for the timer support block
`timescale 1ns/1ps
module tpf_top_props #(
    parameter int NUM_TIMERS = 3
) (
    input logic clock,
    input logic rst_n,
    input logic [1:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    input logic [NUM_TIMERS*3-1:0] clock_select_field,
    input logic [NUM_TIMERS-1:0] ext_count_clock_pin,
    input logic [NUM_TIMERS-1:0] timer_tick,
    input logic t1_tick_match_a,
    input logic t1_force_compare_a,
    input logic t1_match_a_flag,
    input logic t1_tick_overflow,
    input logic t1_overflow_flag,
    input logic [3:0] t1_waveform_mode_field,
    input logic t3_tick_match_a,
    input logic t3_force_compare_a,
    input logic t3_match_a_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    match_sets_a: assert property (t1_tick_match_a && timer_tick[0] && !t1_force_compare_a
        |-> ##2 t1_match_a_flag) else $error("match flag not set");
    force_blocks_a: assert property ($rose(t3_match_a_flag)
        |-> $past(t3_tick_match_a, 2) && !$past(t3_force_compare_a, 2)) else $error("bad set");
    direct_tick_a: assert property (clock_select_field[2:0] == tpf_pkg::TPF_CS_DIRECT
        |-> timer_tick[0]) else $error("direct select gave no tick");
    stop_tick_a: assert property (clock_select_field[2:0] == tpf_pkg::TPF_CS_STOP
        |-> !timer_tick[0]) else $error("stopped timer ticked");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    ovf_sets_a: assert property (t1_tick_overflow && timer_tick[0]
        && t1_waveform_mode_field == tpf_pkg::TPF_WGM_NORMAL |=> t1_overflow_flag)
        else $error("overflow flag not set");
    write_clear_a: assert property (reg_wr && reg_addr == tpf_pkg::TPF_ADDR_FLAGS
        && reg_wdata[4] && !t3_tick_match_a && !$past(t3_tick_match_a) |=> !t3_match_a_flag)
        else $error("write one did not clear");
    ext_delay_a: assert property ($rose(ext_count_clock_pin[2])
        && clock_select_field[8:6] == tpf_pkg::TPF_CS_EXT_RISE |-> ##[1:2] timer_tick[2])
        else $error("external edge not counted in time");
    ext_single_a: assert property (timer_tick[2]
        && clock_select_field[8:6] == tpf_pkg::TPF_CS_EXT_RISE |=> !timer_tick[2])
        else $error("external edge gave long pulse");
endmodule // tpf_top_props
bind tpf_top tpf_top_props #(.NUM_TIMERS(NUM_TIMERS)) u_props (.*);

/* tb/timer_prescaler_and_flags_bench.sv */
// Testbench for the timer support block
`timescale 1ns/1ps
module timer_prescaler_and_flags_bench;
    logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, en = 0, pin;
    logic [1:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, d;
    logic [8:0] csf = 0;
    logic [2:0] tick;
    logic [15:0] ev = 0, r;
    logic [3:0] ack1 = 0;
    logic [5:0] ack3 = 0;
    logic [3:0] wm3 = 0;
    int errors = 0, total_checks = 0, m1 = 0, m3 = 0, k;
    int divs[4] = '{8, 64, 256, 1024};
    always #50 clock = ~clock;
    tpf_ext_src src (.clock(clock), .en(en), .pin(pin));
    tpf_top dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clock_select_field(csf),
        .ext_count_clock_pin({3{pin}}), .timer_tick(tick), .async_prescaler_reset(),
        .t1_tick_match_a(ev[0]), .t1_tick_match_b(ev[1]), .t1_tick_match_c(ev[2]),
        .t1_tick_overflow(ev[3]), .t1_force_compare_a(ev[4]), .t1_force_compare_b(ev[5]),
        .t1_force_compare_c(ev[6]), .t3_tick_match_a(ev[7]), .t3_tick_match_b(ev[8]),
        .t3_tick_match_c(ev[9]), .t3_tick_overflow(ev[10]), .t3_tick_top(ev[11]),
        .t3_capture_event(ev[12]), .t3_force_compare_a(ev[13]), .t3_force_compare_b(ev[14]),
        .t3_force_compare_c(ev[15]), .t1_waveform_mode_field(tpf_pkg::TPF_WGM_NORMAL),
        .t3_waveform_mode_field(wm3), .t1_vector_ack(ack1),
        .t3_vector_ack(ack3), .t1_match_a_flag(), .t1_match_b_flag(), .t1_match_c_flag(),
        .t1_overflow_flag(), .t3_capture_flag(), .t3_match_a_flag(), .t3_match_b_flag(),
        .t3_match_c_flag(), .t3_overflow_flag());
    task chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t saw %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task cnt(input int g, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clock);
            #1 if (tick[g] === 1'b1) c++;
        end
    endtask
    task results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1_000_000 errors++;
        results();
    end
    initial begin
        void'($urandom(32'h6712));
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a < 4; a++) begin rd(2'(a), d); chk(d, 8'h00); end
        wr(2'h3, 8'hFF); rd(2'h3, d); chk(d, 8'h00);
        csf <= {3'h1, 3'h0, 3'h1};
        repeat (24) begin
            r = 16'($urandom);
            @(posedge clock); ev <= r;
            @(posedge clock); ev <= 16'h0;
            repeat (3) @(posedge clock);
            m3 |= {r[12], r[7] & !r[13], r[8] & !r[14], r[10], r[9] & !r[15], r[2] & !r[6]};
            m1 |= {r[0] & !r[4], r[1] & !r[5], r[3], 2'b00};
            rd(2'h0, d); chk(d, 8'(m3));
            rd(2'h2, d); chk(d, 8'(m1));
            r = 16'($urandom);
            wr(2'h0, {2'b00, r[5:0]});
            wr(2'h2, r[15:8] & 8'h1C);
            m3 &= ~int'(r[5:0]);
            m1 &= ~int'(r[15:8] & 8'h1C);
            rd(2'h0, d); chk(d, 8'(m3));
            r = 16'($urandom);
            @(posedge clock); ack1 <= r[3:0]; ack3 <= r[9:4];
            @(posedge clock); ack1 <= 4'h0; ack3 <= 6'h0;
            m3 &= ~int'(r[9:4] | {5'h0, r[0]});
            m1 &= ~int'({r[3:1], 2'b00});
        end
        rd(2'h0, d); chk(d, 8'(m3));
        rd(2'h2, d); chk(d, 8'(m1));
        // Capture-as-TOP mode: pin event ignored, TOP sets capture, CTC overflow sets
        wr(2'h0, 8'h3F); m3 = 0; wm3 <= tpf_pkg::TPF_WGM_CTC_ICR;
        @(posedge clock); ev <= 16'h1000;
        @(posedge clock); ev <= 16'h0000;
        rd(2'h0, d); chk(d, 8'h00);
        @(posedge clock); ev <= 16'h0C00;
        @(posedge clock); ev <= 16'h0000;
        rd(2'h0, d); chk(d, 8'h24);
        wr(2'h1, 8'h81); csf <= 9'(tpf_pkg::TPF_CS_DIV8);
        cnt(0, 20, k); chk(8'(k), 8'h00);
        rd(2'h1, d); chk(d, 8'h81);
        wr(2'h1, 8'h00); cnt(0, 16, k); chk(8'(k), 8'h02);
        rd(2'h1, d); chk(d, 8'h00);
        wr(2'h1, 8'h01); rd(2'h1, d); chk(d, 8'h00);
        // Divider restarted from zero: first divide-by-8 tick lands at a fixed place
        cnt(0, 5, k); chk(8'(k), 8'h00);
        cnt(0, 1, k); chk(8'(k), 8'h01);
        for (int i = 0; i < 4; i++) begin
            csf <= {3'h1, 3'h1, 3'(i + 2)};
            cnt(0, 2 * divs[i], k); chk(8'(k), 8'h02);
        end
        for (int s = 7; s > 5; s--) begin
            csf <= {3'(s), 6'h0};
            fork
                cnt(2, 70, k);
                begin en <= 1'b1; repeat (60) @(posedge clock); en <= 1'b0; end
            join
            chk(8'(k), 8'h0A);
        end
        results();
    end
endmodule // timer_prescaler_and_flags_bench
